// file: rtl/sbd_baud_gen.sv
// sbd_baud_gen.sv: prescaler and rate divider for the serial clock.
// assumes run is held high for the whole of a master frame.
`timescale 1ns/100ps

module sbd_baud_gen (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              run,
   input  wire sbd_pkg::sbd_baud_t baud,
   output logic                   half_tick
);
   import sbd_pkg::*;

   logic [2:0] pre_cnt;
   logic [6:0] rate_cnt;

   // half a serial period is prescale times half the rate divisor
   wire [7:0] rate_half = 8'h01 << baud.rate_divisor_select;
   wire [6:0] rate_last = 7'(rate_half - 8'h01);
   wire       pre_wrap  = (pre_cnt == baud.prescale_select);
   wire       rate_wrap = (rate_cnt == rate_last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt   <= 3'h0;
         rate_cnt  <= 7'h00;
         half_tick <= 1'b0;
      end else if (!run) begin
         pre_cnt   <= 3'h0;
         rate_cnt  <= 7'h00;
         half_tick <= 1'b0;
      end else begin
         pre_cnt   <= pre_wrap ? 3'h0 : pre_cnt + 3'h1;
         if (pre_wrap) begin
            rate_cnt <= rate_wrap ? 7'h00 : rate_cnt + 7'h01;
         end
         half_tick <= pre_wrap & rate_wrap;
      end
   end

endmodule : sbd_baud_gen

// file: rtl/sbd_pkg.sv
// sbd_pkg.sv: types shared by the serial peripheral register block.
// assumes nothing of its surroundings.
package sbd_pkg;

   typedef enum logic [0:0] {
      SBD_IDLE  = 1'b0,
      SBD_SHIFT = 1'b1
   } sbd_state_t;

   typedef struct packed {
      logic [2:0] prescale_select;
      logic [2:0] rate_divisor_select;
   } sbd_baud_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } sbd_pins_t;

endpackage : sbd_pkg

// file: rtl/sbd_regs.svh
// sbd_regs.svh: offsets, field positions, reset values and timing counts
// of the serial peripheral register block.
// assumes a 32-bit APB slave decoding an 8-bit byte address.
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SBD_OFS_CTRL      8'h00
`define SBD_OFS_BAUD      8'h04
`define SBD_OFS_STAT      8'h08
`define SBD_OFS_DATA      8'h0C

// ----------------------------------------------------------------------
// first_control_register fields
// ----------------------------------------------------------------------
`define SBD_CTRL_EN       6
`define SBD_CTRL_TIE      5
`define SBD_CTRL_MASTER_SELECT     4
`define SBD_CTRL_FDEN     2
`define SBD_CTRL_SELECT_OUTPUT_ENABLE     1
`define SBD_CTRL_MASK     8'h76

// ----------------------------------------------------------------------
// baud_divisor_config fields
// ----------------------------------------------------------------------
`define SBD_PRE_LSB       4
`define SBD_RATE_LSB      0
`define SBD_BAUD_MASK     8'h77

// ----------------------------------------------------------------------
// serial_status_flags fields
// ----------------------------------------------------------------------
`define SBD_ST_RF         7
`define SBD_ST_TEF        5
`define SBD_ST_MODE_FAULT_FLAG       4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SBD_CTRL_RST      8'h00
`define SBD_BAUD_RST      8'h00
`define SBD_DATA_RST      8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SBD_CLK_NS        100
`define SBD_LOAD_MAX_NS   200
`define SBD_LOAD_MAX_CYC  (`SBD_LOAD_MAX_NS / `SBD_CLK_NS)
`define SBD_FRAME_EDGES   16

`endif

// file: rtl/sbd_spi_regs.sv
// sbd_spi_regs.sv: APB register side of the serial peripheral block,
// with baud generator, status flags, data buffers and mode-0 shifter.
// assumes an APB master on pclk; link pins are asynchronous to pclk.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`include "sbd_regs.svh"

// How it works
// - prescale divides the bus clock by field value plus one
// - rate divider divides further by two to two hundred fifty-six
// - rate divider output is the master serial clock
// - baud register readable and writable at any time
// - unused status bits read zero; status writes ignored
// - receive-full sets when a transfer completes
// - receive-full clears on status read seeing it, then data read
// - transmit-empty shows buffer room; cleared by status read then write
// - data write without prior status read seeing empty is discarded
// - transmit-empty sets when buffer byte moves to shifter
// - idle block moves written byte to shifter within two cycles
// - finished frame reloads queued byte and sets transmit-empty
// - nothing queued at frame end leaves transmit-empty set
// - interrupt request while transmit-empty and its enable are set
// - mode fault sets on select falling in guarded master mode only
// - mode fault clears on status read seeing it, then control write
// - data reads give receive buffer, writes fill transmit buffer
// - in master mode a buffered byte starts a transfer
// - unread receive buffer keeps old byte; new byte is dropped
// - disabling halts transfer, clears buffers, sets transmit-empty
// - master-select chooses master or slave; only master drives clock
module sbd_spi_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic        ss_n_i,
   output logic             ss_n_o,
   output logic             ss_n_oe,
   output logic             irq
);
   import sbd_pkg::*;

   localparam logic [3:0] LAST_EDGE = 4'(`SBD_FRAME_EDGES - 1);
   localparam int         LOAD_CYC  = `SBD_LOAD_MAX_CYC;

   logic [7:0] ctrl_q;
   logic [7:0] baud_q;
   logic [7:0] tx_buf;
   logic [7:0] rx_buf;
   logic [7:0] sh_reg;
   logic       tx_full;
   logic       sh_full;
   logic       rf;
   logic       mode_fault_flag;
   logic       rf_seen;
   logic       tef_seen;
   logic       mode_fault_flag_seen;
   logic       samp;
   logic       out_bit;
   logic       sck_q;
   logic       ss_q;
   logic       half_tick;
   logic [3:0] edge_cnt;
   sbd_state_t state;
   sbd_pins_t  pin_s;
   sbd_baud_t  baud_cfg;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   sbd_sync #(
      .WIDTH   (4),
      .RST_VAL (4'h1)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({sck_i, mosi_i, miso_i, ss_n_i}),
      .q       (pin_s)
   );

   // ----------------------------------------------------------------
   // control decode
   // ----------------------------------------------------------------
   wire en   = ctrl_q[`SBD_CTRL_EN];
   wire tie  = ctrl_q[`SBD_CTRL_TIE];
   wire master_select = ctrl_q[`SBD_CTRL_MASTER_SELECT];
   wire fden = ctrl_q[`SBD_CTRL_FDEN];
   wire select_output_enable = ctrl_q[`SBD_CTRL_SELECT_OUTPUT_ENABLE];
   wire tef  = ~tx_full;
   assign baud_cfg = {baud_q[`SBD_PRE_LSB +: 3], baud_q[`SBD_RATE_LSB +: 3]};

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire acc      = psel & penable & ~pready;
   wire fin      = psel & penable & pready;
   wire hit_ctrl = (paddr == `SBD_OFS_CTRL);
   wire hit_baud = (paddr == `SBD_OFS_BAUD);
   wire hit_stat = (paddr == `SBD_OFS_STAT);
   wire hit_data = (paddr == `SBD_OFS_DATA);
   wire hit_any  = hit_ctrl | hit_baud | hit_stat | hit_data;
   wire wr_ctrl  = fin & pwrite & hit_ctrl;
   wire wr_baud  = fin & pwrite & hit_baud;
   wire wr_data  = fin & pwrite & hit_data;
   wire rd_stat  = fin & ~pwrite & hit_stat;
   wire rd_data  = fin & ~pwrite & hit_data;
   wire data_ok  = wr_data & tef_seen;
   wire rf_clr   = rd_data & rf_seen;
   wire mode_fault_flag_clr = wr_ctrl & mode_fault_flag_seen;

   wire [7:0] stat_vec = (8'(rf) << `SBD_ST_RF)
                       | (8'(tef) << `SBD_ST_TEF)
                       | (8'(mode_fault_flag) << `SBD_ST_MODE_FAULT_FLAG);
   wire [7:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_baud ? baud_q :
                       hit_stat ? stat_vec :
                       hit_data ? rx_buf : 8'h00;

   // ----------------------------------------------------------------
   // shifter decode
   // ----------------------------------------------------------------
   wire sck_rise  = pin_s.sck & ~sck_q;
   wire sck_fall  = ~pin_s.sck & sck_q;
   wire ss_fall   = ss_q & ~pin_s.ss_n;
   wire rise_ev   = master_select ? (half_tick & ~sck_o) : sck_rise;
   wire fall_ev   = master_select ? (half_tick & sck_o) : sck_fall;
   // master reads miso after the synchroniser: half periods under
   // three cycles sample the previous bit
   wire in_bit    = master_select ? pin_s.miso : pin_s.mosi;
   wire shifting  = (state == SBD_SHIFT);
   wire xfer_done = shifting & fall_ev & (edge_cnt == LAST_EDGE);
   wire load_sh   = en & tx_full & ~sh_full & ~shifting;
   wire rx_load   = xfer_done & (~rf | rf_clr);
   wire mode_fault_flag_set  = en & master_select & fden & ~select_output_enable & ss_fall;
   wire slv_abort = shifting & ~master_select & pin_s.ss_n;

   sbd_baud_gen u_baud (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (en & master_select & shifting),
      .baud      (baud_cfg),
      .half_tick (half_tick)
   );

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc;
         pslverr <= acc & ~hit_any;
         prdata  <= (acc & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SBD_CTRL_RST;
         baud_q <= `SBD_BAUD_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0] & `SBD_CTRL_MASK;
         end
         if (wr_baud) begin
            baud_q <= pwdata[7:0] & `SBD_BAUD_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // status read arming and flags
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_seen   <= 1'b0;
         tef_seen  <= 1'b0;
         mode_fault_flag_seen <= 1'b0;
         rf        <= 1'b0;
         mode_fault_flag      <= 1'b0;
      end else begin
         // arm on the value actually returned by the status read
         rf_seen   <= en & (rd_stat ? prdata[`SBD_ST_RF]
                                    : rf_seen & ~rd_data);
         tef_seen  <= en & (rd_stat ? prdata[`SBD_ST_TEF]
                                    : tef_seen & ~wr_data);
         mode_fault_flag_seen <= rd_stat ? prdata[`SBD_ST_MODE_FAULT_FLAG]
                              : mode_fault_flag_seen & ~wr_ctrl;
         rf        <= en & (rx_load | (rf & ~rf_clr));
         mode_fault_flag      <= mode_fault_flag_set | (mode_fault_flag & ~mode_fault_flag_clr);
      end
   end

   // ----------------------------------------------------------------
   // data buffers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf  <= `SBD_DATA_RST;
         rx_buf  <= `SBD_DATA_RST;
         tx_full <= 1'b0;
      end else if (!en) begin
         tx_buf  <= `SBD_DATA_RST;
         rx_buf  <= `SBD_DATA_RST;
         tx_full <= 1'b0;
      end else begin
         if (data_ok) begin
            tx_buf  <= pwdata[7:0];
            tx_full <= 1'b1;
         end else if (load_sh) begin
            tx_full <= 1'b0;
         end
         if (rx_load) begin
            rx_buf <= {sh_reg[6:0], samp};
         end
      end
   end

   // ----------------------------------------------------------------
   // shift engine
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= SBD_IDLE;
         sh_full  <= 1'b0;
         sh_reg   <= 8'h00;
         edge_cnt <= 4'h0;
         samp     <= 1'b0;
         sck_o    <= 1'b0;
         out_bit  <= 1'b0;
      end else if (!en) begin
         state    <= SBD_IDLE;
         sh_full  <= 1'b0;
         sh_reg   <= 8'h00;
         edge_cnt <= 4'h0;
         sck_o    <= 1'b0;
      end else if (load_sh) begin
         sh_reg   <= tx_buf;
         sh_full  <= 1'b1;
         out_bit  <= tx_buf[7];
         edge_cnt <= 4'h0;
         state    <= master_select ? SBD_SHIFT : SBD_IDLE;
      end else if (!shifting) begin
         edge_cnt <= 4'h0;
         if (!master_select && !pin_s.ss_n) begin
            state <= SBD_SHIFT;
         end
      end else if (slv_abort) begin
         state    <= SBD_IDLE;
         edge_cnt <= 4'h0;
      end else begin
         if (master_select && half_tick) begin
            sck_o <= ~sck_o;
         end
         if (rise_ev) begin
            samp <= in_bit;
         end
         if (fall_ev) begin
            sh_reg  <= {sh_reg[6:0], samp};
            out_bit <= sh_reg[6];
         end
         if (rise_ev || fall_ev) begin
            edge_cnt <= edge_cnt + 4'h1;
         end
         if (xfer_done) begin
            state   <= SBD_IDLE;
            sh_full <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drivers and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_q   <= 1'b0;
         ss_q    <= 1'b1;
         sck_oe  <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         ss_n_oe <= 1'b0;
         ss_n_o  <= 1'b1;
         irq     <= 1'b0;
      end else begin
         sck_q   <= pin_s.sck;
         ss_q    <= pin_s.ss_n;
         sck_oe  <= en & master_select;
         mosi_oe <= en & master_select;
         miso_oe <= en & ~master_select & ~pin_s.ss_n;
         ss_n_oe <= en & master_select & fden & select_output_enable;
         ss_n_o  <= ~shifting;
         irq     <= tef & tie;
      end
   end

   assign mosi_o = out_bit;
   assign miso_o = out_bit;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_done_queued;
      xfer_done && tx_full && master_select && en;
   endsequence

   sequence s_reload;
      load_sh ##1 (tef && shifting);
   endsequence

   a_idle_load_fast: assert property (@(posedge pclk) disable iff (!presetn)
      (data_ok && en && !sh_full && !shifting) |=> ##[0:LOAD_CYC] tef)
      else $error("idle write not moved to shifter in time");

   a_write_discard: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_data && !tef_seen && en) |=> $stable(tx_buf))
      else $error("unarmed data write changed the transmit buffer");

   a_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && hit_stat) |=> (prdata & 32'hFFFF_FF4F) == 0)
      else $error("unused status bits not zero");

   a_rf_on_done: assert property (@(posedge pclk) disable iff (!presetn)
      (xfer_done && en) |=> rf)
      else $error("receive-full not set at frame end");

   a_rf_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (rf && en && !(rd_data && rf_seen)) |=> rf)
      else $error("receive-full cleared without read sequence");

   a_rx_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (xfer_done && rf && !rf_clr && en) |=> $stable(rx_buf))
      else $error("unread receive byte overwritten");

   a_tef_reload: assert property (@(posedge pclk) disable iff (!presetn)
      s_done_queued |=> s_reload)
      else $error("queued byte not reloaded after frame");

   a_tef_stays: assert property (@(posedge pclk) disable iff (!presetn)
      (xfer_done && !tx_full && !data_ok && en) |=> (tef && !sh_full))
      else $error("empty buffer changed at frame end");

   a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (tef && tie) |=> irq)
      else $error("interrupt request missing");

   a_mode_fault_flag_guard: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_fault_flag && !(master_select && fden && !select_output_enable)) |=> !mode_fault_flag)
      else $error("mode fault set outside guarded master mode");

   a_mode_fault_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_fault_flag && mode_fault_flag_seen && wr_ctrl && !mode_fault_flag_set) |=> !mode_fault_flag)
      else $error("mode fault not cleared by control write");

   a_disable_clr: assert property (@(posedge pclk) disable iff (!presetn)
      !en |=> (!rf && tef && !shifting))
      else $error("disable did not clear state");

   a_slave_noclk: assert property (@(posedge pclk) disable iff (!presetn)
      !master_select |=> !sck_oe)
      else $error("slave drove the serial clock");

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> ##1 pready)
      else $error("bus access not answered in one wait cycle");

endmodule : sbd_spi_regs

// file: rtl/sbd_sync.sv
// sbd_sync.sv: two flip-flop synchroniser, one per bit.
// assumes asynchronous inputs; output is safe in the pclk domain.
`timescale 1ns/100ps

module sbd_sync #(
   parameter int  WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   if (WIDTH < 1) begin : g_chk
      $error("sbd_sync: WIDTH must be at least 1");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta <= RST_VAL[i];
            q[i] <= RST_VAL[i];
         end else begin
            meta <= d[i];
            q[i] <= meta;
         end
      end
   end

endmodule : sbd_sync

// file: testbench/sbd_spi_peer.sv
// sbd_spi_peer.sv: behavioural mode-0 slave on the serial link.
// assumes select stays low for a frame and the clock idles low.
`timescale 1ns/100ps

module sbd_spi_peer (
   input  wire logic       sck,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte,
   output int              frames
);
   logic [7:0] sh = 8'h00;
   int         nb = 0;
   initial rx_byte = 8'h00;
   initial frames = 0;
   // released line shows the inverse of the last bit
   assign miso = ss_n ? ~sh[7] : sh[7];
   always @(negedge ss_n) begin
      sh = tx_byte;
      nb = 0;
   end
   always @(posedge sck) if (!ss_n) begin
      rx_byte = {rx_byte[6:0], mosi};
      nb = nb + 1;
      if (nb == 8) frames = frames + 1;
   end
   always @(negedge sck) if (!ss_n) sh = {sh[6:0], 1'b0};
endmodule : sbd_spi_peer

// file: testbench/spi_baud_status_data_regs_test.sv
// spi_baud_status_data_regs_test.sv: self-checking bench of the block.
// assumes the register offsets of sbd_regs.svh and a mode-0 peer.
`timescale 1ns/100ps
`include "sbd_regs.svh"

module spi_baud_status_data_regs_test;
   import sbd_pkg::*;
   localparam logic [31:0] TEF = 32'h1 << `SBD_ST_TEF;
   localparam logic [31:0] RF  = 32'h1 << `SBD_ST_RF;
   localparam logic [31:0] MF  = 32'h1 << `SBD_ST_MODE_FAULT_FLAG;
   localparam logic [31:0] EN  = 32'h1 << `SBD_CTRL_EN;
   localparam logic [31:0] MS  = 32'h1 << `SBD_CTRL_MASTER_SELECT;
   localparam logic [31:0] TIE = 32'h1 << `SBD_CTRL_TIE;
   localparam logic [31:0] FD  = 32'h1 << `SBD_CTRL_FDEN;
   localparam logic [31:0] SO  = 32'h1 << `SBD_CTRL_SELECT_OUTPUT_ENABLE;
   localparam logic [7:0]  ST  = `SBD_OFS_STAT;
   localparam logic [7:0]  DA  = `SBD_OFS_DATA;
   localparam logic [7:0]  BR  = `SBD_OFS_BAUD;
   localparam logic [7:0]  CT  = `SBD_OFS_CTRL;
   localparam logic [7:0]  BT [3] = '{8'h00, 8'h12, 8'h71};
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, peer_tx = 8'h00, peer_rx;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, irq, err, ss_drv = 1'b1;
   logic        sck_drv = 1'b0, mosi_drv = 1'b0;
   logic [7:0]  sb;
   logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic        ss_n_o, ss_n_oe, peer_miso;
   int          failures = 0, n_checks = 0, cyc = 0, frames;
   wire sck_w  = sck_oe ? sck_o : sck_drv;
   wire mosi_w = mosi_oe ? mosi_o : mosi_drv;
   wire miso_w = miso_oe ? miso_o : peer_miso;
   wire ss_w   = ss_n_oe ? ss_n_o : ss_drv;

   always #50 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   sbd_spi_regs i_sbd_spi_regs (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
      .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
      .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .irq(irq));

   sbd_spi_peer i_sbd_spi_peer (.sck(sck_w), .ss_n(ss_n_o),
      .mosi(mosi_w), .tx_byte(peer_tx), .miso(peer_miso),
      .rx_byte(peer_rx), .frames(frames));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   task automatic tick(input int n);
      repeat (n) @(negedge pclk);
   endtask : tick

   task automatic wait_fr(input int k);
      while (frames < k) @(negedge pclk);
   endtask : wait_fr

   task automatic wait_rf;
      do apb(1'b0, ST, 32'h0); while (rd[`SBD_ST_RF] !== 1'b1);
   endtask : wait_rf

   task automatic half(input logic [31:0] h);
      int t0;
      do @(negedge pclk); while (sck_o !== 1'b1);
      t0 = cyc;
      do @(negedge pclk); while (sck_o !== 1'b0);
      chk(32'(cyc - t0), h);
   endtask : half

   // far-side master: mode 0, half period of eight bus cycles
   task automatic slv(input logic [7:0] m, output logic [7:0] s);
      @(posedge pclk);
      ss_drv <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_drv <= m[i];
         repeat (8) @(posedge pclk);
         sck_drv <= 1'b1;
         s = {s[6:0], miso_w};
         repeat (8) @(posedge pclk);
         sck_drv <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      ss_drv <= 1'b1;
   endtask : slv

   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      close_out;
   end

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdc(ST, TEF);
      rdc(BR, 32'h0);
      rdc(DA, 32'h0);
      apb(1'b1, DA, 32'h3C);
      apb(1'b1, CT, EN | MS);
      apb(1'b1, DA, 32'h3C);
      tick(40);
      rdc(ST, TEF);
      chk(32'(frames), 32'h0);
      apb(1'b1, BR, 32'hFF);
      rdc(BR, 32'h77);
      apb(1'b1, ST, 32'hFF);
      rdc(ST, TEF);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test registers done");
      apb(1'b1, BR, 32'h02);
      peer_tx <= 8'h96;
      rdc(ST, TEF);
      apb(1'b1, DA, 32'hA5);
      rdc(ST, TEF);
      wait_rf;
      chk(rd, RF | TEF);
      rdc(DA, 32'h96);
      chk({24'h0, peer_rx}, 32'hA5);
      rdc(ST, TEF);
      $display("test single frame done");
      apb(1'b1, BR, 32'h03);
      peer_tx <= 8'h5A;
      rdc(ST, TEF);
      apb(1'b1, DA, 32'h11);
      rdc(ST, TEF);
      apb(1'b1, DA, 32'h22);
      rdc(ST, 32'h0);
      wait_fr(2);
      peer_tx <= 8'hC3;
      wait_fr(3);
      tick(20);
      rdc(ST, RF | TEF);
      chk({24'h0, peer_rx}, 32'h22);
      rdc(DA, 32'h5A);
      $display("test queue and overrun done");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, BR, {24'h0, BT[i]});
         rdc(ST, TEF);
         apb(1'b1, DA, 32'h0F);
         half(32'((BT[i][6:4] + 32'd1) << BT[i][2:0]));
         wait_rf;
         apb(1'b0, DA, 32'h0);
      end
      $display("test baud done");
      apb(1'b1, CT, EN | MS | TIE);
      tick(3);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, CT, EN | MS);
      tick(3);
      chk({31'h0, irq}, 32'h0);
      @(posedge pclk) ss_drv <= 1'b0;
      tick(6);
      rdc(ST, TEF);
      @(posedge pclk) ss_drv <= 1'b1;
      apb(1'b1, CT, EN | MS | FD);
      @(posedge pclk) ss_drv <= 1'b0;
      tick(6);
      rdc(ST, TEF | MF);
      @(posedge pclk) ss_drv <= 1'b1;
      apb(1'b1, CT, EN | MS | FD);
      rdc(ST, TEF);
      $display("test irq and fault done");
      apb(1'b1, CT, EN);
      rdc(ST, TEF);
      apb(1'b1, DA, 32'h3A);
      slv(8'hC5, sb);
      chk({24'h0, sb}, 32'h3A);
      chk({30'h0, sck_oe, mosi_oe}, 32'h0);
      rdc(ST, RF | TEF);
      rdc(DA, 32'hC5);
      $display("test slave done");
      apb(1'b1, CT, EN | MS | FD | SO);
      apb(1'b1, BR, 32'h07);
      rdc(ST, TEF);
      apb(1'b1, DA, 32'h55);
      rdc(ST, TEF);
      apb(1'b1, DA, 32'h66);
      rdc(ST, 32'h0);
      chk({30'h0, ss_n_oe, ss_n_o}, 32'h2);
      apb(1'b1, CT, MS);
      rdc(ST, TEF);
      $display("test disable done");
      close_out;
   end
endmodule : spi_baud_status_data_regs_test
